// *** common/ext_irq_map.svh ***
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// register indices; byte address is four times the index
`define IDX_EXT_LINE_ENABLE 10'h03d
`define IDX_EXT_LINE_FLAGS 10'h03c
`define IDX_SENSE_CONTROL 10'h069
`define IDX_PC_GROUP_ENABLE 10'h068
`define IDX_PC_FLAGS 10'h03b
`define IDX_GROUP_TWO_MASK 10'h06d
`define IDX_GROUP_ONE_MASK 10'h06c
`define IDX_GROUP_ZERO_MASK 10'h06b

// field positions
`define LINE0_SENSE_LSB 0
`define LINE1_SENSE_LSB 2
`define LINE0_BIT 0
`define LINE1_BIT 1

// reset values and used-bit masks
`define RESET_BYTE 8'h00
`define SENSE_USED 8'h0f
`define EXT_USED 8'h03
`define PC_USED 8'h07
`define MASK1_USED 8'h7f

// bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// *** common/ext_irq_pkg.sv ***
package ext_irq_pkg;

  // trigger selection for one dedicated line
  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'b00,
    SENSE_ANY_CHANGE = 2'b01,
    SENSE_FALLING = 2'b10,
    SENSE_RISING = 2'b11
  } sense_mode_t;

  // one bit per interrupt vector
  typedef struct packed {
    logic group_two;
    logic group_one;
    logic group_zero;
    logic line_one;
    logic line_zero;
  } irq_vec_t;

endpackage

// *** rtl/external_pin_interrupts.sv ***
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ext_irq_map.svh"
// What this block does
// - pins trigger even when driven as outputs
// - group two pins 23:16, one 14:8, zero 7:0
// - per-group masks pick contributing pins
// - pin-change detection needs no I/O clock
// - line one sense bits 3:2 select trigger
// - line zero sense bits 1:0, same encoding
// - level mode requests while pin stays low
// - edge recognition runs on I/O clock
// - low-level detection works without I/O clock
// - level dropped before start-up gives no request
// - pin sampled before edges; wide pulses caught
// - line enable and global bit gate requests
// - each dedicated line has its own vector
// - edge or change sets the line flag
// - flag clears on vector entry or write-one
// - line flag reads zero in level mode
// - group enables and global bit gate groups
// - each pin-change group has its own vector
// - change on pins 23:16 sets group two flag
// - unused mask, flag, control bits read zero
// - sense control upper four bits read zero
// - group one and zero flags behave alike
// - mask bit works only with group enable
module external_pin_interrupts #(
  parameter int ADDR_W = 12,
  parameter int CHANGE_PINS = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] ext_line_pin,
  input wire logic [CHANGE_PINS-1:0] change_pin,
  input wire logic io_clk_en,
  input wire logic startup_done,
  input wire logic global_irq_enable,
  input wire ext_irq_pkg::irq_vec_t vector_taken,
  output ext_irq_pkg::irq_vec_t irq_req,
  output logic wake_req
);
  import ext_irq_pkg::*;

  // the word index is taken from address bits 11:2, so narrower buses cannot work
  if (ADDR_W < 12 || CHANGE_PINS != 24) begin : g_param_check
    $error("external_pin_interrupts: ADDR_W must be >= 12 and CHANGE_PINS 24");
  end

  logic [7:0] sense_control_reg, ext_line_enable_reg, ext_line_flags_reg;
  logic [7:0] pin_change_group_enable_reg, pin_change_flags_reg;
  logic [7:0] group_two_pin_mask_reg, group_one_pin_mask_reg, group_zero_pin_mask_reg;

  // bus slave state
  logic aw_full_reg, w_full_reg, wr_lane0_reg, awready_reg, wready_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [9:0] wr_index_reg;
  logic [7:0] wr_byte_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // pin sampling state
  logic [1:0] line_meta_reg, line_sync_reg, line_sample_reg, line_prev_reg;
  logic [CHANGE_PINS-1:0] change_meta_reg, change_sync_reg, change_prev_reg;
  irq_vec_t irq_req_reg;
  logic wake_req_reg;

  logic aw_hs, w_hs, do_write, aw_full_next, w_full_next, bvalid_next, rd_hit, wr_hit;
  logic [9:0] rd_index;
  logic [7:0] rd_byte;
  logic [1:0] ext_flag_clear, line_level, line_edge;
  logic [2:0] pc_flag_clear, group_change;
  sense_mode_t line_mode [2];
  logic [CHANGE_PINS-1:0] pin_toggled;

  // write channel handshakes; address and data may arrive in either order
  assign aw_hs = s_axi_awvalid && awready_reg;
  assign w_hs = s_axi_wvalid && wready_reg;
  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign aw_full_next = do_write ? 1'b0 : (aw_full_reg || aw_hs);
  assign w_full_next = do_write ? 1'b0 : (w_full_reg || w_hs);
  assign bvalid_next = do_write || (bvalid_reg && !s_axi_bready);

  // write side: holds each half until the other arrives, then answers once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      wr_index_reg <= 10'h000;
      wr_byte_reg <= 8'h00;
      wr_lane0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= !aw_full_next && !bvalid_next;
      wready_reg <= !w_full_next && !bvalid_next;
      if (aw_hs) begin
        wr_index_reg <= s_axi_awaddr[11:2];
      end
      if (w_hs) begin
        wr_byte_reg <= s_axi_wdata[7:0];
        wr_lane0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end
    end
  end

  // address decode for writes
  always_comb begin
    if (wr_index_reg == `IDX_SENSE_CONTROL) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_EXT_LINE_ENABLE) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_EXT_LINE_FLAGS) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_PC_GROUP_ENABLE) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_PC_FLAGS) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_GROUP_TWO_MASK) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_GROUP_ONE_MASK) begin
      wr_hit = 1'b1;
    end else if (wr_index_reg == `IDX_GROUP_ZERO_MASK) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // control registers; unused bits never store, so they read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_control_reg <= `RESET_BYTE;
      ext_line_enable_reg <= `RESET_BYTE;
      pin_change_group_enable_reg <= `RESET_BYTE;
      group_two_pin_mask_reg <= `RESET_BYTE;
      group_one_pin_mask_reg <= `RESET_BYTE;
      group_zero_pin_mask_reg <= `RESET_BYTE;
    end else if (do_write && wr_lane0_reg) begin
      if (wr_index_reg == `IDX_SENSE_CONTROL) begin
        sense_control_reg <= wr_byte_reg & `SENSE_USED;
      end else if (wr_index_reg == `IDX_EXT_LINE_ENABLE) begin
        ext_line_enable_reg <= wr_byte_reg & `EXT_USED;
      end else if (wr_index_reg == `IDX_PC_GROUP_ENABLE) begin
        pin_change_group_enable_reg <= wr_byte_reg & `PC_USED;
      end else if (wr_index_reg == `IDX_GROUP_TWO_MASK) begin
        group_two_pin_mask_reg <= wr_byte_reg;
      end else if (wr_index_reg == `IDX_GROUP_ONE_MASK) begin
        group_one_pin_mask_reg <= wr_byte_reg & `MASK1_USED;
      end else if (wr_index_reg == `IDX_GROUP_ZERO_MASK) begin
        group_zero_pin_mask_reg <= wr_byte_reg;
      end
    end
  end

  // write-one clears, applied alongside vector entry
  assign ext_flag_clear = (do_write && wr_lane0_reg && wr_index_reg == `IDX_EXT_LINE_FLAGS)
                          ? wr_byte_reg[1:0] : 2'b00;
  assign pc_flag_clear = (do_write && wr_lane0_reg && wr_index_reg == `IDX_PC_FLAGS)
                         ? wr_byte_reg[2:0] : 3'b000;

  // read side: data is registered, answer the cycle after the address is taken
  assign rd_index = s_axi_araddr[11:2];

  always_comb begin
    rd_hit = 1'b1;
    if (rd_index == `IDX_SENSE_CONTROL) begin
      rd_byte = sense_control_reg;
    end else if (rd_index == `IDX_EXT_LINE_ENABLE) begin
      rd_byte = ext_line_enable_reg;
    end else if (rd_index == `IDX_EXT_LINE_FLAGS) begin
      rd_byte = ext_line_flags_reg;
    end else if (rd_index == `IDX_PC_GROUP_ENABLE) begin
      rd_byte = pin_change_group_enable_reg;
    end else if (rd_index == `IDX_PC_FLAGS) begin
      rd_byte = pin_change_flags_reg;
    end else if (rd_index == `IDX_GROUP_TWO_MASK) begin
      rd_byte = group_two_pin_mask_reg;
    end else if (rd_index == `IDX_GROUP_ONE_MASK) begin
      rd_byte = group_one_pin_mask_reg;
    end else if (rd_index == `IDX_GROUP_ZERO_MASK) begin
      rd_byte = group_zero_pin_mask_reg;
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
      rdata_reg <= {24'h00_0000, rd_byte};
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // two-flop synchronisers; pins are read as levels whatever their direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_meta_reg <= 2'b11;
      line_sync_reg <= 2'b11;
      change_meta_reg <= '0;
      change_sync_reg <= '0;
    end else begin
      line_meta_reg <= ext_line_pin;
      line_sync_reg <= line_meta_reg;
      change_meta_reg <= change_pin;
      change_sync_reg <= change_meta_reg;
    end
  end

  // edge sampling only advances while the I/O clock runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_sample_reg <= 2'b11;
      line_prev_reg <= 2'b11;
    end else if (io_clk_en) begin
      line_sample_reg <= line_sync_reg;
      line_prev_reg <= line_sample_reg;
    end
  end

  // trigger selection per dedicated line
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      line_mode[i] = sense_mode_t'(sense_control_reg[2*i +: 2]);
      line_level[i] = !line_sync_reg[i];
      case (line_mode[i])
        SENSE_ANY_CHANGE: line_edge[i] = line_sample_reg[i] ^ line_prev_reg[i];
        SENSE_FALLING: line_edge[i] = line_prev_reg[i] && !line_sample_reg[i];
        SENSE_RISING: line_edge[i] = !line_prev_reg[i] && line_sample_reg[i];
        default: line_edge[i] = 1'b0;
      endcase
    end
  end

  // dedicated-line flags: a fresh edge beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_line_flags_reg <= `RESET_BYTE;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (line_mode[i] == SENSE_LOW_LEVEL) begin
          ext_line_flags_reg[i] <= 1'b0;
        end else begin
          ext_line_flags_reg[i] <= (ext_line_flags_reg[i] && !ext_flag_clear[i]
            && !(i == 0 ? vector_taken.line_zero : vector_taken.line_one))
            || (io_clk_en && line_edge[i]);
        end
      end
    end
  end

  // pin-change detection runs every cycle, independent of the I/O clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_prev_reg <= '0;
    end else begin
      change_prev_reg <= change_sync_reg;
    end
  end

  // a masked pin counts only while its group is enabled
  assign pin_toggled = change_sync_reg ^ change_prev_reg;
  assign group_change[2] = |(pin_toggled[23:16] & group_two_pin_mask_reg)
                           && pin_change_group_enable_reg[2];
  assign group_change[1] = |(pin_toggled[14:8] & group_one_pin_mask_reg[6:0])
                           && pin_change_group_enable_reg[1];
  assign group_change[0] = |(pin_toggled[7:0] & group_zero_pin_mask_reg)
                           && pin_change_group_enable_reg[0];

  // group flags: set wins over vector entry and write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_flags_reg <= `RESET_BYTE;
    end else begin
      pin_change_flags_reg[2] <= (pin_change_flags_reg[2] && !pc_flag_clear[2]
        && !vector_taken.group_two) || group_change[2];
      pin_change_flags_reg[1] <= (pin_change_flags_reg[1] && !pc_flag_clear[1]
        && !vector_taken.group_one) || group_change[1];
      pin_change_flags_reg[0] <= (pin_change_flags_reg[0] && !pc_flag_clear[0]
        && !vector_taken.group_zero) || group_change[0];
    end
  end

  // one request per vector; level lines wait for start-up to finish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_reg <= '0;
    end else begin
      irq_req_reg.line_zero <= global_irq_enable && ext_line_enable_reg[`LINE0_BIT]
        && ((line_mode[0] == SENSE_LOW_LEVEL) ? (line_level[0] && startup_done)
        : ext_line_flags_reg[0]);
      irq_req_reg.line_one <= global_irq_enable && ext_line_enable_reg[`LINE1_BIT]
        && ((line_mode[1] == SENSE_LOW_LEVEL) ? (line_level[1] && startup_done)
        : ext_line_flags_reg[1]);
      irq_req_reg.group_two <= global_irq_enable && pin_change_group_enable_reg[2]
        && pin_change_flags_reg[2];
      irq_req_reg.group_one <= global_irq_enable && pin_change_group_enable_reg[1]
        && pin_change_flags_reg[1];
      irq_req_reg.group_zero <= global_irq_enable && pin_change_group_enable_reg[0]
        && pin_change_flags_reg[0];
    end
  end

  // wake needs no I/O clock: held-low enabled level lines or pin changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= (|group_change)
        || (ext_line_enable_reg[0] && line_mode[0] == SENSE_LOW_LEVEL && line_level[0])
        || (ext_line_enable_reg[1] && line_mode[1] == SENSE_LOW_LEVEL
        && line_level[1]);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq_req = irq_req_reg;
  assign wake_req = wake_req_reg;

endmodule // external_pin_interrupts

// *** verif/ext_irq_asserts.sv ***
`timescale 1ns/1ps
module ext_irq_asserts #(
  parameter int CHANGE_PINS = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CHANGE_PINS-1:0] change_pin,
  input wire logic global_irq_enable,
  input wire ext_irq_pkg::irq_vec_t vector_taken,
  input wire ext_irq_pkg::irq_vec_t irq_req
);
  import ext_irq_pkg::*;

  // one clock domain, so clocking and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  chk_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  chk_line_gated: assert property (!global_irq_enable |=> irq_req.line_one == 1'b0 && irq_req.line_zero == 1'b0)
    else $error("line request without global bit");
  chk_group_gated: assert property (!global_irq_enable |=> irq_req[4:2] == 3'h0)
    else $error("group request without global bit");
  // quiet pins for four samples mean no set can race the clear
  chk_taken_clears: assert property ($stable(change_pin[7:0])[*4] ##0 vector_taken.group_zero |-> ##2 !irq_req.group_zero)
    else $error("group zero request not cleared on vector entry");
endmodule // ext_irq_asserts

bind external_pin_interrupts ext_irq_asserts #(.CHANGE_PINS(CHANGE_PINS)) u_asserts (.aclk, .aresetn,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .change_pin, .global_irq_enable,
  .vector_taken, .irq_req);

// *** verif/cpu_vector_model.sv ***
`timescale 1ns/1ps
module cpu_vector_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic take_en,
  input wire logic [3:0] lat,
  input wire ext_irq_pkg::irq_vec_t irq_req,
  output ext_irq_pkg::irq_vec_t vector_taken
);
  import ext_irq_pkg::*;
  logic [4:0] req_bits;
  logic [3:0] wait_reg;

  assign req_bits = irq_req;

  // enters the lowest pending vector after lat cycles; long holdoff hides irq_req lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_reg <= 4'h0;
      vector_taken <= '0;
    end else begin
      vector_taken <= '0;
      if (!take_en || req_bits == 5'h00) begin
        wait_reg <= lat;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else begin
        vector_taken <= irq_vec_t'(req_bits & ~(req_bits - 5'h01));
        wait_reg <= 4'hf;
      end
    end
  end
endmodule // cpu_vector_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "ext_irq_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import ext_irq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, io_clk_en;
  logic startup_done, global_irq_enable, wake_req, take_en;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb, lat;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext_line_pin;
  logic [23:0] change_pin;
  irq_vec_t vector_taken, irq_req;
  logic [9:0] note_q[$];
  logic [9:0] exp_note;
  logic [9:0] idx_tab[8] = '{`IDX_SENSE_CONTROL, `IDX_EXT_LINE_ENABLE, `IDX_EXT_LINE_FLAGS,
    `IDX_PC_GROUP_ENABLE, `IDX_PC_FLAGS, `IDX_GROUP_TWO_MASK, `IDX_GROUP_ONE_MASK, `IDX_GROUP_ZERO_MASK};
  logic [7:0] used_tab[8] = '{`SENSE_USED, `EXT_USED, 8'h00, `PC_USED, 8'h00, 8'hff, `MASK1_USED, 8'hff};
  int fails = 0;
  int n_tests = 0;

  external_pin_interrupts dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_line_pin, .change_pin, .io_clk_en, .startup_done,
    .global_irq_enable, .vector_taken, .irq_req, .wake_req);
  cpu_vector_model u_cpu (.aclk, .aresetn, .take_en, .lat, .irq_req, .vector_taken);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    note_q.push_back({resp, 8'h00});
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [9:0] exp_v);
    note_q.push_back(exp_v);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // every bus answer is matched against the oldest note
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      // pop once: the macro names its expected value twice
      exp_note = note_q.pop_front();
      `CHK((s_axi_rvalid ? {s_axi_rresp, s_axi_rdata[7:0]} : {s_axi_bresp, 8'h00}), exp_note)
    end
  end

  // a hung handshake would otherwise stall the run
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, change_pin, lat, take_en} = '0;
    {io_clk_en, startup_done, global_irq_enable} = 3'h7;
    s_axi_wstrb = 4'hf;
    ext_line_pin = 2'b11;
    seed = 32'h0b4d;
    tick(20);
    aresetn <= 1'b1;
    tick(3);
    // reset values, random write and read-back, unmapped place
    for (int i = 0; i < 8; i++) rd(idx_tab[i], {`RESP_OKAY, 8'h00});
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(idx_tab[i], seed[7:0], `RESP_OKAY);
      rd(idx_tab[i], {`RESP_OKAY, seed[7:0] & used_tab[i]});
    end
    rd(10'h000, {`RESP_DECERR, 8'h00});
    wr(10'h000, 8'hff, `RESP_DECERR);
    // lane zero strobe low: the write is answered but stores nothing
    s_axi_wstrb <= 4'he;
    wr(`IDX_GROUP_ZERO_MASK, ~seed[7:0], `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`IDX_GROUP_ZERO_MASK, {`RESP_OKAY, seed[7:0]});
    // each group: a masked pin stays silent, an unmasked one flags
    for (int g = 0; g < 3; g++) begin
      wr(`IDX_PC_GROUP_ENABLE, 8'h01 << g, `RESP_OKAY);
      wr(`IDX_GROUP_ZERO_MASK + 10'(g), 8'hfd, `RESP_OKAY);
      change_pin <= change_pin ^ (24'h2 << (8 * g));
      tick(8);
      rd(`IDX_PC_FLAGS, {`RESP_OKAY, 8'h00});
      change_pin <= change_pin ^ (24'h1 << (8 * g));
      tick(8);
      `CHK(irq_req[2 + g], 1'b1)
      rd(`IDX_PC_FLAGS, {`RESP_OKAY, 8'h01 << g});
      wr(`IDX_PC_FLAGS, 8'h01 << g, `RESP_OKAY);
      rd(`IDX_PC_FLAGS, {`RESP_OKAY, 8'h00});
    end
    // edge modes on both lines at once
    wr(`IDX_PC_GROUP_ENABLE, 8'h00, `RESP_OKAY);
    wr(`IDX_EXT_LINE_ENABLE, 8'h03, `RESP_OKAY);
    for (int m = 1; m < 4; m++) begin
      wr(`IDX_SENSE_CONTROL, {4'h0, 2'(m), 2'(m)}, `RESP_OKAY);
      wr(`IDX_EXT_LINE_FLAGS, 8'h03, `RESP_OKAY);
      ext_line_pin <= 2'b00;
      tick(8);
      rd(`IDX_EXT_LINE_FLAGS, {`RESP_OKAY, (m != 3) ? 8'h03 : 8'h00});
      `CHK(irq_req[1:0], ((m != 3) ? 2'b11 : 2'b00))
      wr(`IDX_EXT_LINE_FLAGS, 8'h03, `RESP_OKAY);
      ext_line_pin <= 2'b11;
      tick(8);
      rd(`IDX_EXT_LINE_FLAGS, {`RESP_OKAY, (m != 2) ? 8'h03 : 8'h00});
    end
    // low level: nothing before start-up ends, then requests while held low
    wr(`IDX_SENSE_CONTROL, 8'h00, `RESP_OKAY);
    wr(`IDX_EXT_LINE_FLAGS, 8'h03, `RESP_OKAY);
    startup_done <= 1'b0;
    ext_line_pin <= 2'b00;
    tick(8);
    `CHK(irq_req[1:0], 2'b00)
    `CHK(wake_req, 1'b1)
    startup_done <= 1'b1;
    tick(8);
    `CHK(irq_req[1:0], 2'b11)
    rd(`IDX_EXT_LINE_FLAGS, {`RESP_OKAY, 8'h00});
    global_irq_enable <= 1'b0;
    tick(4);
    `CHK(irq_req[1:0], 2'b00)
    global_irq_enable <= 1'b1;
    ext_line_pin <= 2'b11;
    tick(8);
    `CHK(irq_req[1:0], 2'b00)
    `CHK(wake_req, 1'b0)
    // cpu enters the group zero vector after a slow, random delay
    seed = xs(seed);
    wr(`IDX_PC_GROUP_ENABLE, 8'h01, `RESP_OKAY);
    wr(`IDX_GROUP_ZERO_MASK, 8'hff, `RESP_OKAY);
    take_en <= 1'b1;
    lat <= 4'h4 + {1'b0, seed[2:0]};
    change_pin <= change_pin ^ 24'h80;
    tick(30);
    `CHK(irq_req, irq_vec_t'(5'h00))
    rd(`IDX_PC_FLAGS, {`RESP_OKAY, 8'h00});
    end_of_test();
  end
endmodule // tb_top
